// ### src/ictim_sequencer.v
// Function
// [RL1] each operation yields total clocks plus bus read and write cycle counts
// [RL2] bus cycles take four clocks; leftover clocks are idle; waits add time
// [RL3] marked entries add effective-address clocks, reads and writes
// [RL4] jump via register 8 clocks 2 reads; call 16 clocks 2 reads 2 writes
// [RL5] address load 4 clocks 1 read; address push 12 clocks 1 read 2 writes
// [RL6] multi-register move adds 4 clocks per word, 8 per long register
// [RL7] multi load 12+4n with 3+n reads; store 8+4n with 2 reads n writes
// [RL8] index register size never changes indexed mode timing
// [RL9] multiprecision timing covers operand fetch, operate, store and prefetch
// [RL10] extended add/sub: 4 or 8 clocks in registers; 18 or 30 memory form
// [RL11] status logic 20 clocks 3 reads; external reset 132; stop 4 no bus
// [RL12] exception return 20/5, subroutine return 16/4, link 16/2/2, unlink 12/3
// [RL13] peripheral byte move word 16 clocks, long 24, reads/writes by direction
// [RL14] exception timing includes stacking, vector fetch and first handler fetch
// [RL15] bus/address faults 50 clocks 4/7; trap class 34 clocks 4/3
// [RL16] bounds 40 and divide-by-zero 38 clocks, 4/3, plus effective address
// [RL17] interrupt 44 clocks 5/3 with a four-clock acknowledge cycle
// [RL18] after reset and halt pins negate, 40 clocks 6 reads before execution
// [RL19] delayed acknowledge adds exactly its wait clocks, counts unchanged
`default_nettype none

module ictim_sequencer
(
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire [4:0]  opSel,
  input  wire [3:0]  modeSel,
  input  wire        longSize,
  input  wire        memForm,
  input  wire        toMemory,
  input  wire [4:0]  regCount,
  input  wire [7:0]  eaClocks,
  input  wire [3:0]  eaReads,
  input  wire [3:0]  eaWrites,
  input  wire        busAck,
  input  wire        resetPinActive,
  input  wire        haltPinActive,
  output reg         busy,
  output reg         done,
  output reg         busRead,
  output reg         busWrite,
  output reg         execReady,
  output reg         illegalMode,
  output reg         extResetDrive,
  output reg  [15:0] clocksUsed,
  output reg  [7:0]  readsUsed,
  output reg  [7:0]  writesUsed,
  output reg  [15:0] waitsUsed
);

`include "ictim_regs.vh"

localparam [2:0] ST_IDLE     = 3'h0;
localparam [2:0] ST_READ     = 3'h1;
localparam [2:0] ST_INTERNAL = 3'h2;
localparam [2:0] ST_WRITE    = 3'h3;
localparam [2:0] ST_FINISH   = 3'h4;

reg  [2:0]  state;
reg  [2:0]  next_state;
reg  [4:0]  curOp;
reg  [7:0]  rdLeft;
reg  [7:0]  wrLeft;
reg  [15:0] idleLeft;
reg  [7:0]  baseClk;
reg  [3:0]  baseRd;
reg  [3:0]  baseWr;
reg  [3:0]  perClk;
reg  [1:0]  perRd;
reg  [1:0]  perWr;
reg         addEa;
reg         badMode;
reg  [15:0] totalClk;
reg  [7:0]  totalRd;
reg  [7:0]  totalWr;
reg  [15:0] totalIdle;

wire [4:0]  tableOp;
wire        startupPending;
wire        startupLaunch;
wire        launch;
wire        abort;
wire        busRun;
wire        cycleDone;
wire        waitClock;
wire [1:0]  busPhase;
wire [11:0] jumpRow;
wire [11:0] leaRow;
wire [11:0] multiRow;
wire        flowModeBad;

////////////////////////////////////////////////////////////////////////////////
// stage order: reads, then internal processing, then writes
function [2:0] pickStage;
  input [7:0]  rd;
  input [15:0] idle;
  input [7:0]  wr;
  begin
    if (rd != 8'h00)
      pickStage = ST_READ;
    else if (idle != 16'h0000)
      pickStage = ST_INTERNAL;
    else if (wr != 8'h00)
      pickStage = ST_WRITE;
    else
      pickStage = ST_FINISH;
  end
endfunction

// {clocks, reads}; both indexed modes share one row whatever the index size [RL8]
function [11:0] jumpEntry;
  input [3:0] m;
  begin
    case (m)
      `ICTIM_MODE_IND:                                        jumpEntry = {8'h08, 4'h2}; // [RL4]
      `ICTIM_MODE_DISP, `ICTIM_MODE_ABS_SHORT, `ICTIM_MODE_PC_DISP: jumpEntry = {8'h0A, 4'h2};
      `ICTIM_MODE_INDEX, `ICTIM_MODE_PC_INDEX:                 jumpEntry = {8'h0E, 4'h3}; // [RL8]
      `ICTIM_MODE_ABS_LONG:                                   jumpEntry = {8'h0C, 4'h3};
      default:                                                jumpEntry = {8'h08, 4'h2};
    endcase
  end
endfunction

function [11:0] leaEntry;
  input [3:0] m;
  begin
    case (m)
      `ICTIM_MODE_IND:                                        leaEntry = {8'h04, 4'h1}; // [RL5]
      `ICTIM_MODE_DISP, `ICTIM_MODE_ABS_SHORT, `ICTIM_MODE_PC_DISP: leaEntry = {8'h08, 4'h2};
      `ICTIM_MODE_INDEX, `ICTIM_MODE_PC_INDEX:                 leaEntry = {8'h0C, 4'h2}; // [RL8]
      `ICTIM_MODE_ABS_LONG:                                   leaEntry = {8'h0C, 4'h3};
      default:                                                leaEntry = {8'h04, 4'h1};
    endcase
  end
endfunction

// register-to-memory fixed part; the load direction adds one fetch
function [11:0] multiEntry;
  input [3:0] m;
  begin
    case (m)
      `ICTIM_MODE_IND, `ICTIM_MODE_POSTINC, `ICTIM_MODE_PREDEC: multiEntry = {8'h08, 4'h2}; // [RL7]
      `ICTIM_MODE_DISP, `ICTIM_MODE_ABS_SHORT, `ICTIM_MODE_PC_DISP: multiEntry = {8'h0C, 4'h3};
      `ICTIM_MODE_INDEX, `ICTIM_MODE_PC_INDEX:                 multiEntry = {8'h0E, 4'h3}; // [RL8]
      `ICTIM_MODE_ABS_LONG:                                   multiEntry = {8'h10, 4'h4};
      default:                                                multiEntry = {8'h08, 4'h2};
    endcase
  end
endfunction

assign jumpRow  = jumpEntry(modeSel);
assign leaRow   = leaEntry(modeSel);
assign multiRow = multiEntry(modeSel);
assign flowModeBad = (modeSel == `ICTIM_MODE_POSTINC) || (modeSel == `ICTIM_MODE_PREDEC)
                   || (modeSel > `ICTIM_MODE_PC_INDEX);

////////////////////////////////////////////////////////////////////////////////
// timing table
assign tableOp = startupPending ? `ICTIM_OP_RESET_SEQ : opSel;

always @*
begin
  baseClk = 8'h00;
  baseRd  = 4'h0;
  baseWr  = 4'h0;
  perClk  = 4'h0;
  perRd   = 2'h0;
  perWr   = 2'h0;
  addEa   = 1'b0;
  badMode = 1'b0;
  case (tableOp)
    `ICTIM_OP_JUMP:
    begin
      {baseClk, baseRd} = jumpRow; // [RL4]
      badMode = flowModeBad;
    end
    `ICTIM_OP_CALL:
    begin
      baseClk = jumpRow[11:4] + `ICTIM_PUSH_CLOCKS; // [RL4]
      baseRd  = (leaRow[3:0] < `ICTIM_CALL_MIN_READS) ? `ICTIM_CALL_MIN_READS : leaRow[3:0];
      baseWr  = `ICTIM_PUSH_WRITES;
      badMode = flowModeBad;
    end
    `ICTIM_OP_ADDR_LOAD:
    begin
      {baseClk, baseRd} = leaRow; // [RL5]
      badMode = flowModeBad;
    end
    `ICTIM_OP_ADDR_PUSH:
    begin
      baseClk = leaRow[11:4] + `ICTIM_PUSH_CLOCKS; // [RL5]
      baseRd  = leaRow[3:0];
      baseWr  = `ICTIM_PUSH_WRITES;
      badMode = flowModeBad;
    end
    `ICTIM_OP_MULTI_LOAD:
    begin
      baseClk = multiRow[11:4] + `ICTIM_LOAD_EXTRA_CLK; // [RL7]
      baseRd  = multiRow[3:0] + `ICTIM_LOAD_EXTRA_RD;
      perClk  = longSize ? `ICTIM_LONG_REG_CLOCKS : `ICTIM_WORD_REG_CLOCKS; // [RL6]
      perRd   = longSize ? 2'h2 : 2'h1;
      badMode = (modeSel == `ICTIM_MODE_PREDEC) || (modeSel > `ICTIM_MODE_PC_INDEX);
    end
    `ICTIM_OP_MULTI_STORE:
    begin
      {baseClk, baseRd} = multiRow; // [RL7]
      perClk  = longSize ? `ICTIM_LONG_REG_CLOCKS : `ICTIM_WORD_REG_CLOCKS; // [RL6]
      perWr   = longSize ? 2'h2 : 2'h1;
      badMode = (modeSel == `ICTIM_MODE_POSTINC) || (modeSel >= `ICTIM_MODE_PC_DISP);
    end
    // memory forms fetch both operands, store, then prefetch [RL9]
    `ICTIM_OP_EXT_ADD, `ICTIM_OP_EXT_SUB:
    begin
      if (memForm)
        {baseClk, baseRd, baseWr} = longSize ? {8'h1E, 4'h5, 4'h2} : {8'h12, 4'h3, 4'h1}; // [RL10]
      else
        {baseClk, baseRd} = longSize ? {8'h08, 4'h1} : {8'h04, 4'h1}; // [RL10]
    end
    `ICTIM_OP_MEM_CMP:
      {baseClk, baseRd} = longSize ? {8'h14, 4'h5} : {8'h0C, 4'h3}; // [RL9]
    `ICTIM_OP_DEC_ADD, `ICTIM_OP_DEC_SUB:
    begin
      if (memForm)
        {baseClk, baseRd, baseWr} = {8'h12, 4'h3, 4'h1}; // [RL9]
      else
        {baseClk, baseRd} = {8'h06, 4'h1};
    end
    `ICTIM_OP_STATUS_LOGIC:  {baseClk, baseRd} = {8'h14, 4'h3}; // [RL11]
    `ICTIM_OP_BOUNDS_CHECK:
    begin
      {baseClk, baseRd} = {8'h0A, 4'h1};
      addEa = 1'b1; // [RL3]
    end
    `ICTIM_OP_FRAME_LINK:    {baseClk, baseRd, baseWr} = {8'h10, 4'h2, 4'h2}; // [RL12]
    `ICTIM_OP_FRAME_UNLINK:  {baseClk, baseRd} = {8'h0C, 4'h3}; // [RL12]
    `ICTIM_OP_NOP:           {baseClk, baseRd} = {8'h04, 4'h1};
    `ICTIM_OP_EXT_RESET:     {baseClk, baseRd} = {8'h84, 4'h1}; // [RL11]
    `ICTIM_OP_EXC_RETURN:    {baseClk, baseRd} = {8'h14, 4'h5}; // [RL12]
    `ICTIM_OP_SUB_RETURN:    {baseClk, baseRd} = {8'h10, 4'h4}; // [RL12]
    `ICTIM_OP_STOP:          baseClk = 8'h04; // [RL11]
    `ICTIM_OP_PERIPH_MOVE:
    begin
      if (toMemory)
        {baseClk, baseRd, baseWr} = longSize ? {8'h18, 4'h2, 4'h4} : {8'h10, 4'h2, 4'h2}; // [RL13]
      else
        {baseClk, baseRd} = longSize ? {8'h18, 4'h6} : {8'h10, 4'h4}; // [RL13]
    end
    // exception entries already hold stacking, vector and first handler fetch [RL14]
    `ICTIM_OP_EXC_BUS_FAULT: {baseClk, baseRd, baseWr} = {8'h32, 4'h4, 4'h7}; // [RL15]
    `ICTIM_OP_EXC_TRAP:      {baseClk, baseRd, baseWr} = {8'h22, 4'h4, 4'h3}; // [RL15]
    `ICTIM_OP_EXC_TRAP_OVF:  {baseClk, baseRd, baseWr} = {8'h22, 4'h5, 4'h3};
    `ICTIM_OP_EXC_BOUNDS:
    begin
      {baseClk, baseRd, baseWr} = {8'h28, 4'h4, 4'h3}; // [RL16]
      addEa = 1'b1; // [RL3]
    end
    `ICTIM_OP_EXC_DIV_ZERO:
    begin
      {baseClk, baseRd, baseWr} = {8'h26, 4'h4, 4'h3}; // [RL16]
      addEa = 1'b1; // [RL3]
    end
    // acknowledge counts as one of the reads, four clocks unless stretched [RL17]
    `ICTIM_OP_EXC_INTERRUPT: {baseClk, baseRd, baseWr} = {8'h2C, 4'h5, 4'h3}; // [RL17]
    `ICTIM_OP_RESET_SEQ:     {baseClk, baseRd} = {8'h28, 4'h6}; // [RL18]
    default:                 badMode = 1'b1;
  endcase
end

// totals as clocks plus read and write counts [RL1]
always @*
begin
  totalClk  = {8'h00, baseClk} + (addEa ? {8'h00, eaClocks} : 16'h0000)
            + ({12'h000, perClk} * {11'h000, regCount}); // [RL3] [RL6]
  totalRd   = {4'h0, baseRd} + (addEa ? {4'h0, eaReads} : 8'h00)
            + ({6'h00, perRd} * {3'h0, regCount});
  totalWr   = {4'h0, baseWr} + (addEa ? {4'h0, eaWrites} : 8'h00)
            + ({6'h00, perWr} * {3'h0, regCount});
  // whatever the bus cycles leave over is internal processing [RL2]
  totalIdle = totalClk - {6'h00, totalRd + totalWr, `ICTIM_BUS_CYCLE_SHIFT'h0};
end

////////////////////////////////////////////////////////////////////////////////
// sequencing
assign launch = (state == ST_IDLE) && !resetPinActive && (startupLaunch || (start && !startupPending));
assign abort  = resetPinActive && (state != ST_IDLE);
assign busRun = (state == ST_READ) || (state == ST_WRITE);

always @*
begin
  next_state = state;
  case (state)
    ST_IDLE:
      if (launch)
        next_state = pickStage(totalRd, totalIdle, totalWr);
    ST_READ:
      if (cycleDone && rdLeft == 8'h01)
        next_state = pickStage(8'h00, idleLeft, wrLeft);
    ST_INTERNAL:
      if (idleLeft == 16'h0001)
        next_state = pickStage(8'h00, 16'h0000, wrLeft);
    ST_WRITE:
      if (cycleDone && wrLeft == 8'h01)
        next_state = ST_FINISH;
    ST_FINISH:
      next_state = ST_IDLE;
    default:
      next_state = ST_IDLE;
  endcase
  if (abort)
    next_state = ST_IDLE;
end

always @(posedge clk)
begin
  if (rst)
  begin
    state         <= ST_IDLE;
    curOp         <= 5'h00;
    rdLeft        <= 8'h00;
    wrLeft        <= 8'h00;
    idleLeft      <= 16'h0000;
    busy          <= 1'b0;
    done          <= 1'b0;
    busRead       <= 1'b0;
    busWrite      <= 1'b0;
    execReady     <= 1'b0;
    illegalMode   <= 1'b0;
    extResetDrive <= 1'b0;
    clocksUsed    <= 16'h0000;
    readsUsed     <= 8'h00;
    writesUsed    <= 8'h00;
    waitsUsed     <= 16'h0000;
  end
  else
  begin
    state         <= next_state;
    done          <= (state == ST_FINISH) && !abort;
    busy          <= (next_state != ST_IDLE);
    busRead       <= (next_state == ST_READ);
    busWrite      <= (next_state == ST_WRITE);
    // execution may only begin once the startup sequence has run its course
    execReady     <= !startupPending && !resetPinActive
                     && ((curOp != `ICTIM_OP_RESET_SEQ) || (next_state == ST_IDLE)); // [RL18]
    extResetDrive <= (next_state == ST_INTERNAL) && (curOp == `ICTIM_OP_EXT_RESET);
    if (launch)
    begin
      curOp       <= tableOp;
      rdLeft      <= totalRd;
      wrLeft      <= totalWr;
      idleLeft    <= totalIdle;
      illegalMode <= badMode;
      clocksUsed  <= 16'h0000;
      readsUsed   <= 8'h00;
      writesUsed  <= 8'h00;
      waitsUsed   <= 16'h0000;
      extResetDrive <= (pickStage(totalRd, totalIdle, totalWr) == ST_INTERNAL) && (tableOp == `ICTIM_OP_EXT_RESET);
    end
    else
    begin
      if (state == ST_READ || state == ST_INTERNAL || state == ST_WRITE)
        clocksUsed <= clocksUsed + 16'h0001; // [RL2]
      if (waitClock)
        waitsUsed <= waitsUsed + 16'h0001; // [RL19]
      if (state == ST_READ && cycleDone)
      begin
        rdLeft    <= rdLeft - 8'h01;
        readsUsed <= readsUsed + 8'h01; // [RL19]
      end
      if (state == ST_WRITE && cycleDone)
      begin
        wrLeft     <= wrLeft - 8'h01;
        writesUsed <= writesUsed + 8'h01; // [RL19]
      end
      if (state == ST_INTERNAL)
        idleLeft <= idleLeft - 16'h0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// a stretched acknowledge holds the last phase, only adding clocks [RL19]
ictim_bus_cycle u_bus
(
  .clk       (clk),
  .rst       (rst),
  .run       (busRun),
  .busAck    (busAck),
  .phase     (busPhase),
  .cycleDone (cycleDone),
  .waitClock (waitClock)
);

// startup sequence launches once both pins are seen negated [RL18]
ictim_startup u_startup
(
  .clk            (clk),
  .rst            (rst),
  .resetPinActive (resetPinActive),
  .haltPinActive  (haltPinActive),
  .startupTaken   (launch && startupPending),
  .startupPending (startupPending),
  .startupLaunch  (startupLaunch)
);

endmodule // ictim_sequencer

`default_nettype wire

// ### src/ictim_regs.vh
`ifndef ICTIM_REGS_VH
`define ICTIM_REGS_VH

// bus cycle shape: four clock periods, phase 3 is the acknowledge phase
`define ICTIM_BUS_LAST_PHASE   2'h3
`define ICTIM_BUS_CYCLE_SHIFT  2

// operation select codes
`define ICTIM_OP_JUMP          5'h00
`define ICTIM_OP_CALL          5'h01
`define ICTIM_OP_ADDR_LOAD     5'h02
`define ICTIM_OP_ADDR_PUSH     5'h03
`define ICTIM_OP_MULTI_LOAD    5'h04
`define ICTIM_OP_MULTI_STORE   5'h05
`define ICTIM_OP_EXT_ADD       5'h06
`define ICTIM_OP_EXT_SUB       5'h07
`define ICTIM_OP_MEM_CMP       5'h08
`define ICTIM_OP_DEC_ADD       5'h09
`define ICTIM_OP_DEC_SUB       5'h0A
`define ICTIM_OP_STATUS_LOGIC  5'h0B
`define ICTIM_OP_BOUNDS_CHECK  5'h0C
`define ICTIM_OP_FRAME_LINK    5'h0D
`define ICTIM_OP_FRAME_UNLINK  5'h0E
`define ICTIM_OP_NOP           5'h0F
`define ICTIM_OP_EXT_RESET     5'h10
`define ICTIM_OP_EXC_RETURN    5'h11
`define ICTIM_OP_SUB_RETURN    5'h12
`define ICTIM_OP_STOP          5'h13
`define ICTIM_OP_PERIPH_MOVE   5'h14
`define ICTIM_OP_EXC_BUS_FAULT 5'h15
`define ICTIM_OP_EXC_BOUNDS    5'h16
`define ICTIM_OP_EXC_DIV_ZERO  5'h17
`define ICTIM_OP_EXC_TRAP      5'h18
`define ICTIM_OP_EXC_TRAP_OVF  5'h19
`define ICTIM_OP_EXC_INTERRUPT 5'h1A
`define ICTIM_OP_RESET_SEQ     5'h1B

// addressing mode codes
`define ICTIM_MODE_IND         4'h0
`define ICTIM_MODE_POSTINC     4'h1
`define ICTIM_MODE_PREDEC      4'h2
`define ICTIM_MODE_DISP        4'h3
`define ICTIM_MODE_INDEX       4'h4
`define ICTIM_MODE_ABS_SHORT   4'h5
`define ICTIM_MODE_ABS_LONG    4'h6
`define ICTIM_MODE_PC_DISP     4'h7
`define ICTIM_MODE_PC_INDEX    4'h8

// shared timing adders
`define ICTIM_PUSH_CLOCKS      8'h08
`define ICTIM_PUSH_WRITES      4'h2
`define ICTIM_CALL_MIN_READS   4'h2
`define ICTIM_LOAD_EXTRA_CLK   8'h04
`define ICTIM_LOAD_EXTRA_RD    4'h1
`define ICTIM_WORD_REG_CLOCKS  4'h4
`define ICTIM_LONG_REG_CLOCKS  4'h8

`endif

// ### src/ictim_bus_cycle.v
`default_nettype none

module ictim_bus_cycle
(
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire       busAck,
  output reg  [1:0] phase,
  output wire       cycleDone,
  output wire       waitClock
);

`include "ictim_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// phases wrap straight into the next cycle so back-to-back cycles lose no clock
always @(posedge clk)
begin
  if (rst || !run)
  begin
    phase <= 2'h0;
  end
  else if (phase != `ICTIM_BUS_LAST_PHASE)
  begin
    phase <= phase + 2'h1;
  end
  else if (busAck)
  begin
    phase <= 2'h0;
  end
end

assign cycleDone = run && (phase == `ICTIM_BUS_LAST_PHASE) && busAck;
assign waitClock = run && (phase == `ICTIM_BUS_LAST_PHASE) && !busAck;

endmodule // ictim_bus_cycle

`default_nettype wire

// ### src/ictim_startup.v
`default_nettype none

module ictim_startup
(
  input  wire clk,
  input  wire rst,
  input  wire resetPinActive,
  input  wire haltPinActive,
  input  wire startupTaken,
  output reg  startupPending,
  output wire startupLaunch
);

////////////////////////////////////////////////////////////////////////////////
// a reset pin still asserted wins over the take, so the sequence re-arms
always @(posedge clk)
begin
  if (rst || resetPinActive)
  begin
    startupPending <= 1'b1;
  end
  else if (startupTaken)
  begin
    startupPending <= 1'b0;
  end
end

assign startupLaunch = startupPending && !resetPinActive && !haltPinActive;

endmodule // ictim_startup

`default_nettype wire

// ### testbench/ictim_mem_model.sv
`default_nettype none
module ictim_mem_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       busRead,
  input  wire logic       busWrite,
  input  wire logic [3:0] waitCount,
  output var  logic       busAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  logic       idleLevel;
  wire        active = busRead | busWrite;
  //////////////////////////////////////////////////////////////////////////////
  // a cycle lasts four clocks plus the programmed wait clocks
  always @(posedge clk)
  begin
    if (rst || !active || busAck)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
    idleLevel <= ~idleLevel;
  end
  // a released line wanders, never holding its last value
  always_comb
  begin
    if (active)
      busAck = (cnt >= (5'h03 + {1'b0, waitCount}));
    else
      busAck = idleLevel;
  end
  initial idleLevel = 1'b0;
endmodule // ictim_mem_model
`default_nettype wire

// ### testbench/ictim_chk.sv
`default_nettype none
module ictim_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        resetPinActive,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        busRead,
  input wire logic        busWrite,
  input wire logic        extResetDrive,
  input wire logic [15:0] clocksUsed,
  input wire logic [7:0]  readsUsed,
  input wire logic [7:0]  writesUsed,
  input wire logic [15:0] waitsUsed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  AST_RW_EXCL: assert property (!(busRead && busWrite))
    else $error("read and write cycles overlap");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_DONE_IDLE: assert property (done |-> !busy && !busRead && !busWrite)
    else $error("done while still busy");
  AST_BUS_IN_OP: assert property ((busRead || busWrite) |-> busy)
    else $error("bus cycle outside an operation");
  AST_READ_LEN: assert property (disable iff (rst || resetPinActive) $rose(busRead) |-> busRead [*4])
    else $error("read cycle shorter than four clocks");
  AST_WRITE_LEN: assert property (disable iff (rst || resetPinActive) $rose(busWrite) |-> busWrite [*4])
    else $error("write cycle shorter than four clocks");
  AST_WAIT_STEP: assert property (busy && $past(busy) && (waitsUsed != $past(waitsUsed))
    |-> waitsUsed == $past(waitsUsed) + 16'h0001 && clocksUsed == $past(clocksUsed) + 16'h0001)
    else $error("wait clock not counted once");
  AST_WRITES_LAST: assert property (busWrite && !resetPinActive |=> !busRead)
    else $error("read after a write in one operation");
  AST_TOTAL_COVERS_BUS: assert property (done
    |-> (32'(readsUsed) + 32'(writesUsed)) * 4 + 32'(waitsUsed) <= 32'(clocksUsed))
    else $error("total below bus cycle time");
  AST_EXTRST_QUIET: assert property (extResetDrive |-> !busRead && !busWrite)
    else $error("bus active while external reset driven");
  AST_PIN_ABORT: assert property (resetPinActive |=> !busy && !done)
    else $error("operation survives reset pin");
  COV_DONE: cover property (done);
  COV_WAIT: cover property (busy && waitsUsed != 16'h0000);
  COV_WRITE: cover property ($rose(busWrite));
  COV_EXTRST: cover property ($rose(extResetDrive));
endmodule // ictim_chk

bind ictim_sequencer ictim_chk u_chk
(
  .clk            (clk),
  .rst            (rst),
  .resetPinActive (resetPinActive),
  .busy           (busy),
  .done           (done),
  .busRead        (busRead),
  .busWrite       (busWrite),
  .extResetDrive  (extResetDrive),
  .clocksUsed     (clocksUsed),
  .readsUsed      (readsUsed),
  .writesUsed     (writesUsed),
  .waitsUsed      (waitsUsed)
);
`default_nettype wire

// ### testbench/instruction_cycle_timing_test.sv
`include "ictim_regs.vh"
`default_nettype none
module instruction_cycle_timing_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, start, longSize, memForm, toMemory, resetPinActive, haltPinActive;
  logic [4:0]  opSel, regCount;
  logic [3:0]  modeSel, eaReads, eaWrites, waitCount;
  logic [7:0]  eaClocks;
  wire         busAck, busy, done, busRead, busWrite, execReady, illegalMode, extResetDrive;
  wire  [15:0] clocksUsed, waitsUsed;
  wire  [7:0]  readsUsed, writesUsed;
  int          mismatches, samples_checked;

  ictim_sequencer dut (.clk(clk), .rst(rst), .start(start), .opSel(opSel), .modeSel(modeSel),
    .longSize(longSize), .memForm(memForm), .toMemory(toMemory), .regCount(regCount),
    .eaClocks(eaClocks), .eaReads(eaReads), .eaWrites(eaWrites), .busAck(busAck),
    .resetPinActive(resetPinActive), .haltPinActive(haltPinActive), .busy(busy), .done(done),
    .busRead(busRead), .busWrite(busWrite), .execReady(execReady), .illegalMode(illegalMode),
    .extResetDrive(extResetDrive), .clocksUsed(clocksUsed), .readsUsed(readsUsed),
    .writesUsed(writesUsed), .waitsUsed(waitsUsed));
  ictim_mem_model mem (.clk(clk), .rst(rst), .busRead(busRead), .busWrite(busWrite),
    .waitCount(waitCount), .busAck(busAck));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 600 && done !== 1'b1; i++)
      @(negedge clk);
    check(done, 16'h0001, "done seen");
  endtask
  task automatic expect_counts(input int c, input int r, input int w);
    check(clocksUsed, 16'(c), "clocks");
    check(readsUsed, 16'(r), "reads");
    check(writesUsed, 16'(w), "writes");
  endtask
  task automatic run_op(input logic [4:0] op, input logic [3:0] md, input logic lng, input logic mem,
                        input logic [4:0] n, input int c, input int r, input int w);
    @(posedge clk);
    opSel    <= op;
    modeSel  <= md;
    longSize <= lng;
    memForm  <= mem;
    toMemory <= mem;
    regCount <= n;
    start    <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_done();
    expect_counts(c, r, w);
  endtask
  task automatic op0(input logic [4:0] op, input int c, input int r, input int w);
    run_op(op, `ICTIM_MODE_IND, 1'b0, 1'b0, 5'h00, c, r, w);
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    @(posedge clk);
    haltPinActive <= 1'b0;
    repeat (9) @(negedge clk);
    check(execReady, 16'h0000, "early ready");
    wait_done();
    expect_counts(40, 6, 0);
    check(execReady, 16'h0001, "ready");
  endtask
  task automatic t_flow();
    op0(`ICTIM_OP_JUMP, 8, 2, 0);
    op0(`ICTIM_OP_CALL, 16, 2, 2);
    op0(`ICTIM_OP_ADDR_LOAD, 4, 1, 0);
    op0(`ICTIM_OP_ADDR_PUSH, 12, 1, 2);
    run_op(`ICTIM_OP_JUMP, `ICTIM_MODE_POSTINC, 1'b0, 1'b0, 5'h00, 8, 2, 0);
    check(illegalMode, 16'h0001, "illegal mode");
    run_op(`ICTIM_OP_JUMP, `ICTIM_MODE_INDEX, 1'b1, 1'b0, 5'h00, 14, 3, 0);
    check(illegalMode, 16'h0000, "legal mode");
  endtask
  task automatic t_multi();
    run_op(`ICTIM_OP_MULTI_LOAD, `ICTIM_MODE_IND, 1'b0, 1'b0, 5'h03, 24, 6, 0);
    run_op(`ICTIM_OP_MULTI_LOAD, `ICTIM_MODE_IND, 1'b1, 1'b0, 5'h02, 28, 7, 0);
    run_op(`ICTIM_OP_MULTI_STORE, `ICTIM_MODE_IND, 1'b0, 1'b0, 5'h02, 16, 2, 2);
    run_op(`ICTIM_OP_MULTI_STORE, `ICTIM_MODE_IND, 1'b1, 1'b0, 5'h02, 24, 2, 4);
    run_op(`ICTIM_OP_MULTI_LOAD, `ICTIM_MODE_IND, 1'b0, 1'b0, 5'h00, 12, 3, 0);
  endtask
  task automatic t_arith();
    run_op(`ICTIM_OP_EXT_ADD, `ICTIM_MODE_IND, 1'b0, 1'b0, 5'h00, 4, 1, 0);
    run_op(`ICTIM_OP_EXT_SUB, `ICTIM_MODE_IND, 1'b1, 1'b0, 5'h00, 8, 1, 0);
    run_op(`ICTIM_OP_EXT_ADD, `ICTIM_MODE_IND, 1'b0, 1'b1, 5'h00, 18, 3, 1);
    run_op(`ICTIM_OP_EXT_SUB, `ICTIM_MODE_IND, 1'b1, 1'b1, 5'h00, 30, 5, 2);
  endtask
  task automatic t_misc();
    op0(`ICTIM_OP_STATUS_LOGIC, 20, 3, 0);
    op0(`ICTIM_OP_STOP, 4, 0, 0);
    op0(`ICTIM_OP_EXT_RESET, 132, 1, 0);
    op0(`ICTIM_OP_EXC_RETURN, 20, 5, 0);
    op0(`ICTIM_OP_SUB_RETURN, 16, 4, 0);
    op0(`ICTIM_OP_FRAME_LINK, 16, 2, 2);
    op0(`ICTIM_OP_FRAME_UNLINK, 12, 3, 0);
    run_op(`ICTIM_OP_PERIPH_MOVE, `ICTIM_MODE_IND, 1'b0, 1'b1, 5'h00, 16, 2, 2);
    run_op(`ICTIM_OP_PERIPH_MOVE, `ICTIM_MODE_IND, 1'b1, 1'b0, 5'h00, 24, 6, 0);
  endtask
  task automatic t_exc();
    op0(`ICTIM_OP_EXC_BUS_FAULT, 50, 4, 7);
    op0(`ICTIM_OP_EXC_TRAP, 34, 4, 3);
    op0(`ICTIM_OP_EXC_INTERRUPT, 44, 5, 3);
    // only marked entries take the address cost
    @(posedge clk);
    eaClocks <= 8'h06;
    eaReads  <= 4'h1;
    op0(`ICTIM_OP_EXC_BOUNDS, 46, 5, 3);
    op0(`ICTIM_OP_EXC_DIV_ZERO, 44, 5, 3);
    op0(`ICTIM_OP_JUMP, 8, 2, 0);
  endtask
  task automatic t_waits();
    @(posedge clk);
    waitCount <= 4'h2;
    eaClocks  <= 8'h00;
    eaReads   <= 4'h0;
    op0(`ICTIM_OP_JUMP, 12, 2, 0);
    check(waitsUsed, 16'h0004, "waits");
    op0(`ICTIM_OP_CALL, 24, 2, 2);
  endtask
  task automatic t_abort();
    int i;
    @(posedge clk);
    waitCount <= 4'h0;
    opSel <= `ICTIM_OP_EXT_RESET;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (20) @(posedge clk);
    check(extResetDrive, 16'h0001, "ext reset drive");
    resetPinActive <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({14'h0000, busy, done}, 16'h0000, "abort");
    for (i = 0; i < 150; i++)
    begin
      @(negedge clk);
      check(done, 16'h0000, "done after abort");
    end
    @(posedge clk);
    resetPinActive <= 1'b0;
    @(negedge clk);
    wait_done();
    expect_counts(40, 6, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    longSize = 1'b0;
    memForm = 1'b0;
    toMemory = 1'b0;
    resetPinActive = 1'b0;
    haltPinActive = 1'b1;
    opSel = 5'h00;
    regCount = 5'h00;
    modeSel = 4'h0;
    eaReads = 4'h0;
    eaWrites = 4'h0;
    waitCount = 4'h0;
    eaClocks = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_startup();
    t_flow();
    t_multi();
    t_arith();
    t_misc();
    t_exc();
    t_waits();
    t_abort();
    wrap_up();
  end
endmodule // instruction_cycle_timing_test
`default_nettype wire
